//--- common/fsk_arb_pkg.sv
package fsk_arb_pkg;

	// =========================================================
	// Clock and timing
	// =========================================================
	localparam int CLK_HZ             = 125_000_000;
	localparam int MODEM_BAUD_HZ      = 1200;
	localparam int UART_BAUD_HZ       = 1200;
	// Cycles per modem bit and per UART bit
	localparam int MODEM_BIT_CYC      = CLK_HZ / MODEM_BAUD_HZ;
	localparam int UART_BIT_CYC       = CLK_HZ / UART_BAUD_HZ;
	// Latencies in half bit times: 1.5 bit = 3 halves
	localparam int HALF_BITS_ENQ      = 3;
	localparam int CHAR_BITS          = 11;
	localparam int CD_MARK_BITS       = 3;

	// =========================================================
	// Wishbone register map (byte addresses)
	// =========================================================
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXQ    = 8'h08;
	localparam logic [7:0] ADDR_RXQ    = 8'h0C;

	// CTRL fields
	localparam int CTRL_SEND_REQ  = 0;
	localparam int CTRL_FULL_DUP  = 1;
	localparam int CTRL_INT_LOOP  = 2;
	localparam int CTRL_EXT_LOOP  = 3;
	localparam int CTRL_UART_MODE = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// STATUS fields
	localparam int ST_CTS       = 0;
	localparam int ST_CARRIER   = 1;
	localparam int ST_TX_EMPTY  = 2;
	localparam int ST_TX_FULL   = 3;
	localparam int ST_RX_EMPTY  = 4;
	localparam int ST_RX_FULL   = 5;
	localparam int ST_TX_BUSY   = 6;
	localparam int ST_RX_DROP   = 7;

	// Queue depth
	localparam int QUEUE_DEPTH  = 32;

	// =========================================================
	// Arbiter states
	// =========================================================
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RECV = 3'b010,
		ST_SEND = 3'b100
	} arb_state_t;

endpackage

//--- rtl/byte_queue.sv
`timescale 1ns/10ps
// Synchronous byte queue; a push while full is dropped, contents kept
module byte_queue
	import fsk_arb_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] data_o,
	output logic                  empty_o,
	output logic                  full_o
);
	localparam int AW = $clog2(DEPTH);

	// Pointer wrap trick needs a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("byte_queue: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             do_push;
	logic             do_pop;

	// Gate requests by queue state
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign empty_o = (wr_q == rd_q);
	assign full_o  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign data_o  = mem_q[rd_q[AW-1:0]];

	// Storage; no reset needed for data
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q[AW-1:0]] <= data_i;
		end
	end

	// Pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

//--- rtl/fsk_modem_duplex_arbiter.sv
`timescale 1ns/10ps
// Contract
// [R1] Half duplex: never both chains enabled
// [R2] Reset and idle: demodulator on, modulator off
// [R3] Full duplex enables both chains together
// [R4] Internal loopback routes tone to receive input
// [R5] External loopback: both chains, no internal path
// [R6] Idle: send request high, carrier sense low
// [R7] Carrier: sense high, received bytes queued
// [R8] Receive wins while carrier is present
// [R9] Carrier sense drops below detection threshold
// [R10] Controller drains receive queue promptly
// [R11] Controller requests via pin or bit
// [R12] Grant: sense low, demod off, clear set
// [R13] Carrier holds request pending, bytes queued
// [R14] After grant pop bytes, else send mark
// [R15] Controller waits six bits before preamble
// [R16] Preloaded queue gets one extra preamble; not implemented, queued bytes pop as soon as clear is set
// [R17] UART byte queued 1.5 UART bits late
// [R18] Each character is eleven modem bits
// [R19] Controller inserts gap every five characters
// [R20] Controller holds request until character done
// [R21] Carrier needs three consecutive mark bits
// [R22] Received byte queued 1.5 modem bits late
// [R23] SPI mode loads via queue write register
// [R24] Full receive queue drops new bytes
// [R25] Reset clears grant, request, both queues
module fsk_modem_duplex_arbiter
	import fsk_arb_pkg::*;
#(
	parameter int MODEM_BIT   = MODEM_BIT_CYC,
	parameter int UART_BIT    = UART_BIT_CYC,
	parameter int DEPTH       = QUEUE_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Controller side
	input  wire logic        send_req_n_i,
	output logic             carrier_sense_o,
	output logic             clear_to_send_o,
	input  wire logic        uart_byte_valid_i,
	input  wire logic [7:0]  uart_byte_i,
	output logic             uart_out_valid_o,
	output logic [7:0]       uart_out_byte_o,
	input  wire logic        uart_out_ready_i,
	// Analog side
	input  wire logic        carrier_level_ok_i,
	input  wire logic        mark_bit_i,
	input  wire logic        rx_byte_valid_i,
	input  wire logic [7:0]  rx_byte_i,
	output logic             mod_en_o,
	output logic             demod_en_o,
	output logic             loop_internal_o,
	output logic             tx_tone_mark_o,
	output logic             tx_bit_o
);
	if (MODEM_BIT < 4 || UART_BIT < 4) begin : g_bit_check
		$error("fsk_modem_duplex_arbiter: bit times too short");
	end

	// =========================================================
	// Declarations
	// =========================================================
	logic [4:0]  ctrl_q;
	arb_state_t  state_q;
	arb_state_t  state_d;
	logic        carrier_q;
	logic [1:0]  mark_cnt_q;
	logic        rx_drop_q;
	logic [31:0] txd_cnt_q;
	logic [7:0]  txd_byte_q;
	logic        txd_pend_q;
	logic [31:0] rxd_cnt_q;
	logic [7:0]  rxd_byte_q;
	logic        rxd_pend_q;
	logic [31:0] bit_cnt_q;
	logic [3:0]  bit_idx_q;
	logic [10:0] shift_q;
	logic        char_busy_q;
	logic        txq_push;
	logic [7:0]  txq_din;
	logic        txq_pop;
	logic [7:0]  txq_dout;
	logic        txq_empty;
	logic        txq_full;
	logic        rxq_pop;
	logic [7:0]  rxq_dout;
	logic        rxq_empty;
	logic        rxq_full;
	logic        bus_req;
	logic        req_active;
	logic        both_on;
	logic        wr_txq;
	logic        rd_rxq;
	logic        uart_mode;
	logic        push_rx;
	logic [31:0] rx_tick_q;
	logic        rx_tick;

	assign bus_req   = cyc_i && stb_i && !ack_o;
	assign uart_mode = ctrl_q[CTRL_UART_MODE];
	// Either pin (active low) or control bit raises a request
	assign req_active = !send_req_n_i || ctrl_q[CTRL_SEND_REQ];
	// [R3] Duplex selects
	assign both_on = ctrl_q[CTRL_FULL_DUP] || ctrl_q[CTRL_INT_LOOP] ||
		ctrl_q[CTRL_EXT_LOOP];
	assign wr_txq = bus_req && we_i && sel_i[0] && (adr_i == ADDR_TXQ) && !uart_mode;
	assign rd_rxq = bus_req && !we_i && (adr_i == ADDR_RXQ) && !uart_mode;

	// =========================================================
	// Register bus
	// =========================================================
	// Control register; ack one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			ack_o  <= 1'b0;
			dat_o  <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req;
			dat_o <= 32'h0000_0000;
			if (bus_req && we_i && sel_i[0] && adr_i == ADDR_CTRL) begin
				ctrl_q <= dat_i[4:0];
			end
			if (bus_req && !we_i) begin
				case (adr_i)
					ADDR_CTRL:   dat_o <= {27'h0, ctrl_q};
					ADDR_STATUS: dat_o <= {24'h0, rx_drop_q, char_busy_q, rxq_full,
						rxq_empty, txq_full, txq_empty, carrier_q, clear_to_send_o};
					ADDR_RXQ:    dat_o <= {23'h0, rxq_empty, rxq_dout};
					default:     dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// =========================================================
	// Carrier detection
	// =========================================================
	// [R21] Three mark bits before carrier; counted in modem bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carrier_q  <= 1'b0;
			mark_cnt_q <= 2'd0;
		end else if (!carrier_level_ok_i) begin
			// [R9] Level lost drops sense
			carrier_q  <= 1'b0;
			mark_cnt_q <= 2'd0;
		end else if (!demod_en_o) begin
			mark_cnt_q <= 2'd0;
		end else if (rx_tick) begin
			if (!mark_bit_i) begin
				mark_cnt_q <= 2'd0;
			end else if (mark_cnt_q == 2'(CD_MARK_BITS - 1)) begin
				carrier_q <= 1'b1;
			end else begin
				mark_cnt_q <= mark_cnt_q + 2'd1;
			end
		end
	end

	// Free-running modem bit tick for sampling mark bits
	assign rx_tick = (rx_tick_q == 32'(MODEM_BIT - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_tick) begin
			rx_tick_q <= 32'h0000_0000;
		end else begin
			rx_tick_q <= rx_tick_q + 32'h0000_0001;
		end
	end

	// =========================================================
	// Arbitration
	// =========================================================
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				// [R8] Receive has top priority
				if (carrier_q) begin
					state_d = ST_RECV;
				// [R12] Grant when bus free
				end else if (req_active) begin
					state_d = ST_SEND;
				end
			end
			ST_RECV: begin
				// [R13] Request stays pending
				if (!carrier_q) begin
					state_d = req_active ? ST_SEND : ST_IDLE;
				end
			end
			ST_SEND: begin
				if (!req_active) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// [R25] Reset to receive-only idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Registered outputs derived from next state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// [R2] Demod on after reset
			demod_en_o      <= 1'b1;
			mod_en_o        <= 1'b0;
			clear_to_send_o <= 1'b0;
			carrier_sense_o <= 1'b0;
			loop_internal_o <= 1'b0;
		end else begin
			// [R1] One chain in half duplex
			mod_en_o        <= (state_d == ST_SEND) || both_on;
			demod_en_o      <= (state_d != ST_SEND) || both_on;
			// [R12] Clear flag on grant
			clear_to_send_o <= (state_d == ST_SEND);
			// [R6] Sense low unless receiving
			carrier_sense_o <= (state_d == ST_RECV) || (both_on && carrier_q);
			// [R4] Internal loop path
			// [R5] External loopback leaves the path open
			loop_internal_o <= ctrl_q[CTRL_INT_LOOP];
		end
	end

	// =========================================================
	// Transmit path
	// =========================================================
	// [R17] UART byte enqueued 1.5 UART bits after stop bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_pend_q <= 1'b0;
			txd_cnt_q  <= 32'h0000_0000;
			txd_byte_q <= 8'h00;
		end else if (uart_mode && uart_byte_valid_i) begin
			txd_pend_q <= 1'b1;
			txd_byte_q <= uart_byte_i;
			txd_cnt_q  <= 32'(UART_BIT * HALF_BITS_ENQ / 2);
		end else if (txd_pend_q) begin
			if (txd_cnt_q == 32'h0000_0000) begin
				txd_pend_q <= 1'b0;
			end else begin
				txd_cnt_q <= txd_cnt_q - 32'h0000_0001;
			end
		end
	end

	// [R13] Bytes queue even while held
	assign txq_push = (txd_pend_q && txd_cnt_q == 32'h0000_0000) || wr_txq;
	assign txq_din  = wr_txq ? dat_i[7:0] : txd_byte_q;
	// [R14] Pop only when granted and idle
	assign txq_pop  = mod_en_o && clear_to_send_o && !char_busy_q && !txq_empty;

	// [R18] Eleven-bit framing: start, 8 data, parity, stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			char_busy_q <= 1'b0;
			bit_cnt_q   <= 32'h0000_0000;
			bit_idx_q   <= 4'd0;
			shift_q     <= 11'h7FF;
		end else if (txq_pop) begin
			char_busy_q <= 1'b1;
			bit_cnt_q   <= 32'(MODEM_BIT - 1);
			bit_idx_q   <= 4'(CHAR_BITS - 1);
			shift_q     <= {1'b1, ~^txq_dout, txq_dout, 1'b0};
		end else if (char_busy_q) begin
			if (bit_cnt_q != 32'h0000_0000) begin
				bit_cnt_q <= bit_cnt_q - 32'h0000_0001;
			end else if (bit_idx_q == 4'd0) begin
				char_busy_q <= 1'b0;
				shift_q     <= 11'h7FF;
			end else begin
				bit_cnt_q <= 32'(MODEM_BIT - 1);
				bit_idx_q <= bit_idx_q - 4'd1;
				shift_q   <= {1'b1, shift_q[10:1]};
			end
		end
	end

	// [R14] Mark tone when queue empty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_bit_o       <= 1'b1;
			tx_tone_mark_o <= 1'b1;
		end else begin
			tx_bit_o       <= char_busy_q ? shift_q[0] : 1'b1;
			tx_tone_mark_o <= !char_busy_q || shift_q[0];
		end
	end

	// =========================================================
	// Receive path
	// =========================================================
	// [R22] Received byte enqueued 1.5 modem bits late
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd_pend_q <= 1'b0;
			rxd_cnt_q  <= 32'h0000_0000;
			rxd_byte_q <= 8'h00;
		end else if (rx_byte_valid_i && demod_en_o) begin
			rxd_pend_q <= 1'b1;
			rxd_byte_q <= rx_byte_i;
			rxd_cnt_q  <= 32'(MODEM_BIT * HALF_BITS_ENQ / 2);
		end else if (rxd_pend_q) begin
			if (rxd_cnt_q == 32'h0000_0000) begin
				rxd_pend_q <= 1'b0;
			end else begin
				rxd_cnt_q <= rxd_cnt_q - 32'h0000_0001;
			end
		end
	end

	// [R7] Automatic enqueue of received bytes
	assign push_rx = rxd_pend_q && rxd_cnt_q == 32'h0000_0000;

	// [R24] Full queue drops arrivals; sticky, set wins over read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_drop_q <= 1'b0;
		end else if (push_rx && rxq_full) begin
			rx_drop_q <= 1'b1;
		end else if (bus_req && !we_i && adr_i == ADDR_STATUS) begin
			rx_drop_q <= 1'b0;
		end
	end

	// UART forward of received bytes; pops as it is offered
	assign rxq_pop = uart_mode ? (!rxq_empty && (!uart_out_valid_o || uart_out_ready_i)) : rd_rxq;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uart_out_valid_o <= 1'b0;
			uart_out_byte_o  <= 8'h00;
		end else if (uart_mode && rxq_pop) begin
			uart_out_valid_o <= 1'b1;
			uart_out_byte_o  <= rxq_dout;
		end else if (uart_out_ready_i) begin
			uart_out_valid_o <= 1'b0;
		end
	end

	// =========================================================
	// Queues
	// =========================================================
	// [R25] Queues emptied by reset
	byte_queue #(.WIDTH(8), .DEPTH(DEPTH)) tx_queue (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.push_i  (txq_push),
		.data_i  (txq_din),
		.pop_i   (txq_pop),
		.data_o  (txq_dout),
		.empty_o (txq_empty),
		.full_o  (txq_full)
	);

	byte_queue #(.WIDTH(8), .DEPTH(DEPTH)) rx_queue (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.push_i  (push_rx),
		.data_i  (rxd_byte_q),
		.pop_i   (rxq_pop),
		.data_o  (rxq_dout),
		.empty_o (rxq_empty),
		.full_o  (rxq_full)
	);
endmodule

//--- verif/fsk_arb_asserts.sv
`timescale 1ns/10ps
// ==========================================
// Port-level checks for the duplex arbiter
module fsk_arb_asserts
	import fsk_arb_pkg::*;
#(
	parameter int MODEM_BIT = MODEM_BIT_CYC
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic        send_req_n_i,
	input wire logic        carrier_sense_o,
	input wire logic        clear_to_send_o,
	input wire logic        carrier_level_ok_i,
	input wire logic        mark_bit_i,
	input wire logic        mod_en_o,
	input wire logic        demod_en_o
);
	logic        both_q;
	logic        req_q;
	logic [31:0] mark_q;
	logic        wr_ctrl;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Mode shadow taken on the accepting edge, like the block itself
	assign wr_ctrl = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == ADDR_CTRL;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			both_q <= 1'b0;
			req_q  <= 1'b0;
		end else if (wr_ctrl) begin
			both_q <= |dat_i[3:1];
			req_q  <= dat_i[0];
		end
	end

	// Run length of valid mark; a gap restarts it
	always_ff @(posedge clk_i) begin
		if (rst_i || !(carrier_level_ok_i && mark_bit_i)) begin
			mark_q <= 32'h0;
		end else begin
			mark_q <= mark_q + 32'h1;
		end
	end

	// Arbitration relations; four idle cycles cover the mode change
	property p_half; (!both_q) [*4] |-> !(mod_en_o && demod_en_o); endproperty
	a_half: assert property (p_half) else $error("both chains on");
	property p_rst; $fell(rst_i) |-> demod_en_o && !mod_en_o && !clear_to_send_o; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_grant; clear_to_send_o |-> mod_en_o && !carrier_sense_o; endproperty
	a_grant: assert property (p_grant) else $error("grant without modulator");
	property p_prio; carrier_sense_o |-> !clear_to_send_o && demod_en_o; endproperty
	a_prio: assert property (p_prio) else $error("send during carrier");
	// Level loss clears the detector, then the registered sense output
	property p_drop; !carrier_level_ok_i |=> ##1 !carrier_sense_o; endproperty
	a_drop: assert property (p_drop) else $error("carrier sense late to drop");
	property p_rise; $rose(carrier_sense_o) |-> mark_q >= 2 * MODEM_BIT; endproperty
	a_rise: assert property (p_rise) else $error("carrier on short preamble");
	property p_rel; (send_req_n_i && !req_q) [*3] |-> !clear_to_send_o; endproperty
	a_rel: assert property (p_rel) else $error("grant kept without request");
	property p_cause; $rose(clear_to_send_o) |-> !send_req_n_i || req_q; endproperty
	a_cause: assert property (p_cause) else $error("grant without request");

	// Main scenarios seen
	c_grant: cover property ($rose(clear_to_send_o));
	c_carrier: cover property ($rose(carrier_sense_o));
	c_both: cover property (mod_en_o && demod_en_o);
endmodule

bind fsk_modem_duplex_arbiter fsk_arb_asserts #(.MODEM_BIT(MODEM_BIT)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
	.send_req_n_i(send_req_n_i), .carrier_sense_o(carrier_sense_o),
	.clear_to_send_o(clear_to_send_o), .carrier_level_ok_i(carrier_level_ok_i),
	.mark_bit_i(mark_bit_i), .mod_en_o(mod_en_o), .demod_en_o(demod_en_o)
);

//--- verif/fsk_bus_model.sv
`timescale 1ns/10ps
// ==========================================
// Field-bus side: carrier level, mark bits, bytes
module fsk_bus_model (
	input  wire logic       clk_i,
	input  wire logic       carrier_on_i,
	input  wire logic       byte_go_i,
	input  wire logic [7:0] byte_val_i,
	output logic            level_ok_o,
	output logic            mark_o,
	output logic            byte_valid_o,
	output logic [7:0]      byte_o
);
	// Known levels before the first edge
	initial begin
		level_ok_o = 1'b0;
		mark_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'h5A;
	end
	// Carrier is a steady mark; without it the bit line churns
	always @(posedge clk_i) begin
		level_ok_o <= carrier_on_i;
		mark_o <= carrier_on_i | ~mark_o;
		byte_valid_o <= byte_go_i;
		byte_o <= byte_go_i ? byte_val_i : ~byte_o;
	end
endmodule

//--- verif/fsk_modem_duplex_arbiter_test.sv
`timescale 1ns/10ps
// ==========================================
// Bench: arbiter against a field-bus model
module fsk_modem_duplex_arbiter_test;
	import fsk_arb_pkg::*;
	localparam int MB = 8;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic        req_n = 1'b1;
	logic        u_v = 1'b0;
	logic [7:0]  u_b = 8'h00;
	logic        c_on = 1'b0;
	logic        b_go = 1'b0;
	logic [7:0]  b_val = 8'h00;
	logic [31:0] dat_o, rd;
	logic        ack_o, cs, cts, mod_en, demod_en, loop_in, tone, tx_bit, lvl, mark, rx_v;
	logic [7:0]  rx_b, u_ob;
	logic        u_ov;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cycles = 0;

	fsk_modem_duplex_arbiter #(.MODEM_BIT(MB), .UART_BIT(MB)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.send_req_n_i(req_n), .carrier_sense_o(cs), .clear_to_send_o(cts),
		.uart_byte_valid_i(u_v), .uart_byte_i(u_b), .uart_out_valid_o(u_ov),
		.uart_out_byte_o(u_ob), .uart_out_ready_i(1'b1), .carrier_level_ok_i(lvl),
		.mark_bit_i(mark), .rx_byte_valid_i(rx_v), .rx_byte_i(rx_b), .mod_en_o(mod_en),
		.demod_en_o(demod_en), .loop_internal_o(loop_in),
		.tx_tone_mark_o(tone), .tx_bit_o(tx_bit)
	);
	fsk_bus_model far (
		.clk_i(clk_i), .carrier_on_i(c_on), .byte_go_i(b_go), .byte_val_i(b_val),
		.level_ok_o(lvl), .mark_o(mark), .byte_valid_o(rx_v), .byte_o(rx_b)
	);

	// 125 MHz clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Watchdog so a stuck handshake cannot hang the run
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single cycle; entered just after a rising edge
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic t_idle();
		check({cts, cs, mod_en, demod_en}, 32'h1);
		wb(ADDR_CTRL, 1'b0, 32'h0);
		check(rd, 32'h0);
		wb(ADDR_STATUS, 1'b0, 32'h0);
		check(rd, 32'h14);
		wb(8'h10, 1'b0, 32'h0);
		check(rd, 32'h0);
	endtask

	task automatic t_duplex();
		logic [3:0] mode [3] = '{4'h2, 4'h4, 4'h8};
		for (int n = 0; n < 3; n++) begin
			wb(ADDR_CTRL, 1'b1, {28'h0, mode[n]});
			repeat (2) @(posedge clk_i);
			check(mod_en & demod_en, 1'b1);
			check(loop_in, mode[n][2]);
		end
		wb(ADDR_CTRL, 1'b1, 32'h0);
		repeat (2) @(posedge clk_i);
		check({mod_en, demod_en}, 32'h1);
	endtask

	task automatic t_receive();
		int n;
		c_on <= 1'b1;
		for (n = 0; n < 100 && cs !== 1'b1; n++) @(posedge clk_i);
		check({cs, mod_en}, 32'h2);
		req_n <= 1'b0;
		repeat (3 * MB) @(posedge clk_i);
		check({cts, demod_en}, 32'h1);
		b_val <= 8'h3C;
		b_go <= 1'b1;
		@(posedge clk_i);
		b_go <= 1'b0;
		repeat (4) @(posedge clk_i);
		wb(ADDR_STATUS, 1'b0, 32'h0);
		check(rd[4], 1'b1);
		repeat (2 * MB) @(posedge clk_i);
		wb(ADDR_RXQ, 1'b0, 32'h0);
		check(rd, 32'h3C);
		// Deliberately left undrained: one byte past depth must be dropped
		for (n = 0; n <= QUEUE_DEPTH; n++) begin
			b_val <= 8'(n + 16);
			b_go <= 1'b1;
			@(posedge clk_i);
			b_go <= 1'b0;
			repeat (2 * MB) @(posedge clk_i);
		end
		wb(ADDR_STATUS, 1'b0, 32'h0);
		check(rd[7:4], 4'hA);
		wb(ADDR_RXQ, 1'b0, 32'h0);
		check(rd, 32'h10);
		c_on <= 1'b0;
		// Level, detector and sense output each take one register stage
		repeat (4) @(posedge clk_i);
		check(cs, 1'b0);
		for (n = 0; n < 40 && cts !== 1'b1; n++) @(posedge clk_i);
		check({cts, mod_en, demod_en, tone}, 32'hD);
	endtask

	task automatic t_send();
		logic [10:0] f;
		// Stop 1, odd parity 1, data A5 LSB first, start 0
		f = 11'h74A;
		// not exercised: queue stays empty until the grant
		repeat (6 * MB) @(posedge clk_i);
		wb(ADDR_TXQ, 1'b1, 32'hA5);
		for (int n = 0; n < 40 && tx_bit !== 1'b0; n++) @(posedge clk_i);
		repeat (MB / 2) @(posedge clk_i);
		for (int n = 0; n < 11; n++) begin
			check(tx_bit, f[n]);
			repeat (MB) @(posedge clk_i);
		end
		// release only after the stop bit
		req_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		check({cts, mod_en, demod_en}, 32'h1);
	endtask

	task automatic t_uart();
		wb(ADDR_CTRL, 1'b1, 32'h10);
		// Head of the receive queue left from the overflow scenario
		check({u_ov, u_ob}, 32'h111);
		// equal rates and one character: no gap needed
		u_b <= 8'h81;
		u_v <= 1'b1;
		@(posedge clk_i);
		u_v <= 1'b0;
		u_b <= 8'h7E;
		repeat (4) @(posedge clk_i);
		wb(ADDR_STATUS, 1'b0, 32'h0);
		check(rd[2], 1'b1);
		repeat (2 * MB) @(posedge clk_i);
		wb(ADDR_STATUS, 1'b0, 32'h0);
		check(rd[2], 1'b0);
	endtask

	// Main sequence; second reset must empty the loaded queue
	initial begin
		do_reset();
		t_idle();
		t_duplex();
		t_receive();
		t_send();
		t_uart();
		do_reset();
		t_idle();
		tally_and_finish();
	end
endmodule
